// ==== bench/fe_monitor.sv ====
`timescale 1ns/1ns
module fe_monitor
	import fn_enable_pkg::*;
(
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire cfg_req_t    req,
	input wire logic [63:0] capability_fuses,
	input wire logic        claim,
	input wire logic        rd_valid,
	input wire logic [31:0] rdata,
	input wire visible_t    visible
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_fuse(int b); capability_fuses[b][*3]; endsequence
	property p_hb; visible.host_bridge; endproperty
	property p_cas; !visible.engine_fn[0] |-> visible.engine_fn[3:1] == 3'h0; endproperty
	property p_f57; s_fuse(57) |-> visible.engine_fn == 4'h0; endproperty
	property p_f56; s_fuse(56) |-> visible.engine_fn[3:2] == 2'h0; endproperty
	property p_rv; req.rd |=> rd_valid; endproperty
	property p_un; req.rd && !claim |=> rdata == ALL_ONES; endproperty
	property p_rsv; req.rd && claim && req.dev == DEV_HOST && req.ofs == FUNCTION_ENABLE_OFS
		|=> (rdata & ~FUNCTION_ENABLE_WMASK) == (FUNCTION_ENABLE_RST & ~FUNCTION_ENABLE_WMASK); endproperty
	property p_d6; req.rd && req.bus == 8'h00 && req.dev == DEV_SECOND && req.fn == 3'h0
		|-> claim == visible.second_port; endproperty
	a_hb: assert property (p_hb) else $error("host bridge hidden");
	a_cas: assert property (p_cas) else $error("engine fn shown without fn0");
	a_f57: assert property (p_f57) else $error("engine shown with fuse 57");
	a_f56: assert property (p_f56) else $error("engine fn2/3 shown with fuse 56");
	a_rv: assert property (p_rv) else $error("no read valid");
	a_un: assert property (p_un) else $error("unclaimed read not all ones");
	a_rsv: assert property (p_rsv) else $error("fixed bits wrong");
	a_d6: assert property (p_d6) else $error("port claim wrong");
endmodule : fe_monitor
bind function_enable_reg fe_monitor fe_monitor_i (.clock, .sys_rst, .req, .capability_fuses, .claim, .rd_valid,
	.rdata, .visible);

// ==== bench/function_enable_reg_test.sv ====
`timescale 1ns/1ns
module function_enable_reg_test;
	import fn_enable_pkg::*;
	logic clock = 0, sys_rst = 1, lock_active = 0, claim, rd_valid;
	logic [63:0] capability_fuses = '0;
	cfg_req_t req = '0;
	logic [31:0] rdata;
	visible_t visible;
	int err_count = 0, checks = 0;
	logic [70:0] rows [5] = '{{32'h0, 32'h19, 7'h40}, {ALL_ONES, 32'h23DB, 7'h7F}, {32'h2000, 32'h2019, 7'h41},
		{32'h381, 32'h399, 7'h40}, {32'h42, 32'h5B, 7'h62}};
	function_enable_reg function_enable_reg_i (.clock, .sys_rst, .req, .capability_fuses, .lock_active,
		.claim, .rd_valid, .rdata, .visible);
	always #5 clock = ~clock;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [4:0] d, input logic [31:0] wd, input logic ec = 1'b1);
		req <= '{rd: !w, wr: w, bus: 8'h00, dev: d, fn: 3'h0, ofs: 8'h54, be: 4'hF, wdata: wd};
		#1;
		chk("claim", 32'(claim), 32'(ec));
		@(posedge clock);
		#1;
		req.rd <= 1'b0;
		req.wr <= 1'b0;
		if (!w) chk("rd_valid", 32'(rd_valid), 32'h1);
		@(posedge clock);
		#1;
	endtask : acc
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		acc(0, DEV_HOST, 0);
		chk("reset value", rdata, FUNCTION_ENABLE_RST);
		foreach (rows[i]) begin
			acc(1, DEV_HOST, rows[i][70:39]);
			acc(0, DEV_HOST, 0);
			chk("readback", rdata, rows[i][38:7]);
			chk("visible", 32'(visible), 32'(rows[i][6:0]));
		end
		$display("table done");
		lock_active <= 1'b1;
		repeat (3) @(posedge clock);
		acc(1, DEV_HOST, 0);
		acc(0, DEV_HOST, 0);
		chk("locked", rdata, 32'h5B);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		acc(0, DEV_HOST, 0);
		chk("reset again", rdata, FUNCTION_ENABLE_RST);
		lock_active <= 1'b0;
		repeat (3) @(posedge clock);
		acc(1, DEV_HOST, ALL_ONES);
		capability_fuses[56] <= 1'b1;
		repeat (3) @(posedge clock);
		chk("fuse56", 32'(visible), 32'h67);
		acc(0, DEV_SECOND, 0);
		chk("second port read", rdata, 32'h0000_0000);
		capability_fuses[57] <= 1'b1;
		repeat (3) @(posedge clock);
		chk("fuse57", 32'(visible), 32'h61);
		acc(0, DEV_ENGINE, 0, 1'b0);
		chk("hidden read", rdata, ALL_ONES);
		$display("awkward cases done");
		summarize();
	end
endmodule : function_enable_reg_test

// ==== logic/fn_enable_pkg.sv ====
// Contract
// - register sits at bus 0 device 0 function 0, byte offsets 54h-57h, 32 bits
// - reset value reads 000023DBh, reserved upper bits zero
// - bit 13 enables and shows device 6; cleared hides it
// - bit 9 enables and shows device 3 function 3
// - bit 8 enables and shows device 3 function 2
// - bit 7 enables and shows device 3 function 1
// - bit 6 enables and shows device 3 function 0
// - engine function 0 hidden hides engine functions 1, 2 and 3
// - fuse 57 or fuse 56 set hides engine functions 2 and 3
// - fuse 57 set hides engine functions 0 and 1
// - bit 1 enables and shows device 1 function 0
// - bit 0 is read-only, always one; host bridge never disabled
package fn_enable_pkg;
	localparam logic [7:0]  FUNCTION_ENABLE_OFS = 8'h54;
	localparam logic [31:0] FUNCTION_ENABLE_RST = 32'h0000_23DB;
	localparam logic [31:0] FUNCTION_ENABLE_WMASK = 32'h0000_23C2;
	localparam logic [31:0] ALL_ONES            = 32'hFFFF_FFFF;
	localparam int HOST_BRIDGE_BIT  = 0;
	localparam int FIRST_PORT_BIT   = 1;
	localparam int ENGINE_FN0_BIT   = 6;
	localparam int ENGINE_FN1_BIT   = 7;
	localparam int ENGINE_FN2_BIT   = 8;
	localparam int ENGINE_FN3_BIT   = 9;
	localparam int SECOND_PORT_BIT  = 13;
	localparam int FUSE_NO_ENGINE   = 57;
	localparam int FUSE_NO_ENGINE_X = 56;
	localparam logic [4:0] DEV_HOST   = 5'h00;
	localparam logic [4:0] DEV_FIRST  = 5'h01;
	localparam logic [4:0] DEV_ENGINE = 5'h03;
	localparam logic [4:0] DEV_SECOND = 5'h06;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] bus;
		logic [4:0] dev;
		logic [2:0] fn;
		logic [7:0] ofs;
		logic [3:0] be;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic       host_bridge;
		logic       first_port;
		logic [3:0] engine_fn;
		logic       second_port;
	} visible_t;
endpackage : fn_enable_pkg

// ==== logic/function_enable_reg.sv ====
`timescale 1ns/1ns
module function_enable_reg
	import fn_enable_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  sys_rst,
	input  wire fn_enable_pkg::cfg_req_t req,
	input  wire logic [63:0]           capability_fuses,
	input  wire logic                  lock_active,
	output logic                       claim,
	output logic                       rd_valid,
	output logic [31:0]                rdata,
	output fn_enable_pkg::visible_t    visible
);
	logic [31:0] function_enable_r;
	logic [63:0] fuse_s1_r;
	logic [63:0] fuse_r;
	logic        lock_s1_r;
	logic        lock_r;
	logic        own_hit;
	logic        fn_claimed;
	logic [31:0] wmask;
	logic [31:0] function_enable_nxt;
	logic        no_engine;
	logic        no_engine_hi;

	// straps and lock come from outside the clock domain
	always_ff @(posedge clock) begin
		fuse_s1_r <= capability_fuses;
		fuse_r    <= fuse_s1_r;
		lock_s1_r <= lock_active;
		lock_r    <= lock_s1_r;
	end

	assign no_engine    = fuse_r[FUSE_NO_ENGINE];
	assign no_engine_hi = fuse_r[FUSE_NO_ENGINE] | fuse_r[FUSE_NO_ENGINE_X];

	// effective visibility of each function
	always_comb begin
		visible.host_bridge  = 1'b1;
		visible.first_port   = function_enable_r[FIRST_PORT_BIT];
		visible.second_port  = function_enable_r[SECOND_PORT_BIT];
		visible.engine_fn[0] = function_enable_r[ENGINE_FN0_BIT] & ~no_engine;
		visible.engine_fn[1] = function_enable_r[ENGINE_FN1_BIT] & ~no_engine & visible.engine_fn[0];
		visible.engine_fn[2] = function_enable_r[ENGINE_FN2_BIT] & ~no_engine_hi & visible.engine_fn[0];
		visible.engine_fn[3] = function_enable_r[ENGINE_FN3_BIT] & ~no_engine_hi & visible.engine_fn[0];
	end

	// which function the access targets and whether it is claimed
	always_comb begin
		fn_claimed = 1'b0;
		if (req.bus == 8'h00) begin
			case (req.dev)
				DEV_HOST:   fn_claimed = (req.fn == 3'h0);
				DEV_FIRST:  fn_claimed = (req.fn == 3'h0) & visible.first_port;
				DEV_ENGINE: fn_claimed = ~req.fn[2] & visible.engine_fn[req.fn[1:0]];
				DEV_SECOND: fn_claimed = (req.fn == 3'h0) & visible.second_port;
				default:    fn_claimed = 1'b0;
			endcase
		end
	end

	assign claim   = (req.rd | req.wr) & fn_claimed;
	assign own_hit = fn_claimed & (req.dev == DEV_HOST) & (req.ofs[7:2] == FUNCTION_ENABLE_OFS[7:2]);

	// byte-lane write mask limited to writable bits
	always_comb begin
		wmask = {{8{req.be[3]}}, {8{req.be[2]}}, {8{req.be[1]}}, {8{req.be[0]}}} & FUNCTION_ENABLE_WMASK;
		function_enable_nxt = (function_enable_r & ~wmask) | (req.wdata & wmask);
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			function_enable_r <= FUNCTION_ENABLE_RST;
		end else if (req.wr & own_hit & ~lock_r) begin
			function_enable_r <= function_enable_nxt | FUNCTION_ENABLE_RST & ~FUNCTION_ENABLE_WMASK;
		end
	end

	// read answer one cycle after the request
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rd_valid <= 1'b0;
			rdata    <= 32'h0000_0000;
		end else begin
			rd_valid <= req.rd;
			if (req.rd) begin
				if (!fn_claimed)
					rdata <= ALL_ONES;
				else if (own_hit)
					rdata <= function_enable_r;
				else
					rdata <= 32'h0000_0000;
			end
		end
	end
endmodule : function_enable_reg
